// file: hitc_core.sv
`timescale 1ns/1ps
`default_nettype none
module hitc_core #(
    parameter int WDOG_CYCLES = hitc_pkg::WDOG_CYCLES,
    parameter int RECHECK_CYCLES = hitc_pkg::RECHECK_CYCLES
) (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CE,
    // link side; clock, strobe and word on the link clock, busy synchronised to CLK like the pins
    input wire logic LINK_CLK,
    input wire logic LINK_WR,
    input wire hitc_pkg::hitc_wr_t LINK_WORD,
    input wire logic LINK_BUSY,
    // asynchronous pins
    input wire logic EXT_FIRE_PIN,
    input wire logic OVER_TEMP_PIN,
    input wire logic SHORT_PIN,
    // same-clock inputs
    input wire logic [7:0] INPUT_LEVEL,
    input wire logic [7:0] SUPPLY_SAMPLE,
    input wire logic SEQ_DONE,
    input wire logic OTP_PROGRAM,
    input wire logic STATUS_CLEAR,
    // drive outputs
    output logic DRIVE_EN,
    output logic [7:0] DRIVE_LEVEL,
    output logic FIXED_FREQ,
    output logic [6:0] FIXED_PERIOD,
    // state outputs
    output logic FIRE_BIT,
    output logic [2:0] MODE,
    output logic STANDBY,
    output logic SHUTDOWN,
    output hitc_pkg::hitc_stat_t STATUS,
    output logic [7:0] SUPPLY_LEVEL,
    output logic PROTO_RST,
    output hitc_pkg::hitc_cfg_t CONFIG
);
    localparam int WD_W = $clog2(WDOG_CYCLES + 1);
    localparam int RC_W = $clog2(RECHECK_CYCLES + 1);
    localparam logic [WD_W-1:0] WD_LAST = WD_W'(WDOG_CYCLES - 1);
    localparam logic [RC_W-1:0] RC_LAST = RC_W'(RECHECK_CYCLES - 1);
    localparam logic [2:0] PR_LAST = 3'(hitc_pkg::PRST_CYCLES - 1);

    typedef enum logic [1:0] {S_LOAD, S_RUN, S_PROG} hitc_init_t;

    function automatic logic is_cont(input hitc_pkg::hitc_mode_t m);
        return (m == hitc_pkg::MODE_INPUT) || (m == hitc_pkg::MODE_DIRECT);
    endfunction

    function automatic logic [7:0] ng_gate(input logic [7:0] v,
                                           input logic [1:0] sel);
        logic [7:0] th;
        th = 8'h00;
        unique case (sel)
            2'd0: th = 8'h00;
            2'd1: th = hitc_pkg::NG_LVL1;
            2'd2: th = hitc_pkg::NG_LVL2;
            2'd3: th = hitc_pkg::NG_LVL3;
        endcase
        return (v < th) ? 8'h00 : v;
    endfunction

    hitc_pkg::hitc_wr_t link_hold;
    logic link_tgl;
    logic [3:0] s1_reg, s2_reg;
    logic t1_reg, t2_reg, t3_reg, fire_d_reg;
    logic [7:0] mode_reg, amp_reg, ctrl_reg;
    logic [6:0] period_reg;
    hitc_pkg::hitc_cfg_t cfg_reg;
    hitc_init_t st_reg;
    logic [2:0] cnt_reg;
    logic otp_ok_reg;
    logic go_reg, go_next;
    logic ot_reg, short_reg, shut_reg;
    logic [RC_W-1:0] rc_reg;
    logic [WD_W-1:0] wd_reg;
    logic prst_reg;
    logic [2:0] pr_cnt_reg;
    logic drv_en_reg, ffreq_reg;
    logic [7:0] drv_lvl_reg, supply_reg;
    logic otp_we;
    logic [2:0] otp_waddr, otp_raddr, cfg_idx;
    logic [7:0] otp_wdata, otp_rdata;

    hitc_link_rx u_link (
        .link_clk(LINK_CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .proto_rst(prst_reg),
        .wr(LINK_WR),
        .wr_in(LINK_WORD),
        .hold(link_hold),
        .tgl(link_tgl)
    );

    hitc_otp_mem u_otp (
        .clk(CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .we(otp_we),
        .waddr(otp_waddr),
        .wdata(otp_wdata),
        .raddr(otp_raddr),
        .rdata(otp_rdata)
    );

    // pins and link toggle through two flops
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s1_reg <= 4'h0;
            s2_reg <= 4'h0;
            t1_reg <= 1'b0;
            t2_reg <= 1'b0;
            t3_reg <= 1'b0;
            fire_d_reg <= 1'b0;
        end else if (CE) begin
            s1_reg <= {LINK_BUSY, SHORT_PIN, OVER_TEMP_PIN, EXT_FIRE_PIN};
            s2_reg <= s1_reg;
            t1_reg <= link_tgl;
            t2_reg <= t1_reg;
            t3_reg <= t2_reg;
            fire_d_reg <= s2_reg[0];
        end
    end

    wire pin_fire = s2_reg[0];
    wire pin_ot = s2_reg[1];
    wire pin_short = s2_reg[2];
    wire busy = s2_reg[3];
    wire fire_rise = pin_fire & ~fire_d_reg;
    wire wr_evt = t2_reg ^ t3_reg;
    wire [7:0] wa = link_hold.addr;
    wire [7:0] wd = link_hold.data;
    wire wr_mode = wr_evt && (wa == hitc_pkg::ADDR_MODE);
    wire wr_amp = wr_evt && (wa == hitc_pkg::ADDR_AMP);
    wire wr_fire = wr_evt && (wa == hitc_pkg::ADDR_FIRE);
    wire wr_ctrl = wr_evt && (wa == hitc_pkg::ADDR_CTRL);
    wire wr_per = wr_evt && (wa == hitc_pkg::ADDR_PERIOD);
    wire wr_cfg = wr_evt && (wa >= hitc_pkg::ADDR_CFG_LO)
        && (wa <= hitc_pkg::ADDR_CFG_HI);
    wire dev_rst = wr_mode && wd[hitc_pkg::DEV_RESET_BIT];
    wire recover = shut_reg && (rc_reg == RC_LAST) && !pin_short;
    wire init_req = dev_rst | recover;
    wire hitc_pkg::hitc_mode_t mode = hitc_pkg::hitc_mode_t'(mode_reg[2:0]);
    wire standby = mode_reg[hitc_pkg::STANDBY_BIT];
    wire halt = shut_reg | pin_ot;

    // control registers; contents kept across standby
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_reg <= hitc_pkg::MODE_RST;
            amp_reg <= hitc_pkg::AMP_RST;
            ctrl_reg <= hitc_pkg::CTRL_RST;
            period_reg <= hitc_pkg::PERIOD_RST;
        end else if (CE) begin
            if (init_req) begin
                mode_reg <= hitc_pkg::MODE_RST;
                amp_reg <= hitc_pkg::AMP_RST;
                ctrl_reg <= hitc_pkg::CTRL_RST;
                period_reg <= hitc_pkg::PERIOD_RST;
            end else begin
                if (wr_mode) begin
                    mode_reg <= {1'b0, wd[6:0]};
                end
                if (wr_amp) begin
                    amp_reg <= wd;
                end
                if (wr_ctrl) begin
                    ctrl_reg <= wd;
                end
                if (wr_per) begin
                    period_reg <= wd[6:0];
                end
            end
        end
    end

    // retained store: marker at cnt 1, words from cnt 2
    assign otp_raddr = (cnt_reg == 3'd0) ? hitc_pkg::OTP_MARK_ADDR
        : 3'(cnt_reg - 3'd1);
    assign otp_we = (st_reg == S_PROG);
    assign otp_waddr = (cnt_reg < hitc_pkg::OTP_WORDS) ? cnt_reg
        : hitc_pkg::OTP_MARK_ADDR;
    assign otp_wdata = (cnt_reg < hitc_pkg::OTP_WORDS)
        ? cfg_reg.word[cnt_reg] : hitc_pkg::OTP_MARKER;
    assign cfg_idx = 3'(wa - hitc_pkg::ADDR_CFG_LO);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_reg <= S_LOAD;
            cnt_reg <= 3'd0;
            otp_ok_reg <= 1'b0;
            cfg_reg <= {5{hitc_pkg::CFG_RST}};
        end else if (CE) begin
            if (init_req) begin
                st_reg <= S_LOAD;
                cnt_reg <= 3'd0;
                cfg_reg <= {5{hitc_pkg::CFG_RST}};
            end else begin
                unique case (st_reg)
                    S_LOAD: begin
                        cnt_reg <= 3'(cnt_reg + 3'd1);
                        if (cnt_reg == 3'd1) begin
                            otp_ok_reg <= (otp_rdata == hitc_pkg::OTP_MARKER);
                        end
                        if (cnt_reg >= 3'd2 && otp_ok_reg) begin
                            cfg_reg.word[3'(cnt_reg - 3'd2)] <= otp_rdata;
                        end
                        if (cnt_reg == 3'd6) begin
                            st_reg <= S_RUN;
                        end
                    end
                    S_RUN: begin
                        if (wr_cfg) begin
                            cfg_reg.word[cfg_idx] <= wd;
                        end
                        if (OTP_PROGRAM) begin
                            st_reg <= S_PROG;
                            cnt_reg <= 3'd0;
                        end
                    end
                    S_PROG: begin
                        cnt_reg <= 3'(cnt_reg + 3'd1);
                        if (cnt_reg == hitc_pkg::OTP_WORDS) begin
                            st_reg <= S_RUN;
                            cnt_reg <= 3'd0;
                        end
                    end
                endcase
            end
        end
    end

    // fire bit; later lines take priority, so a set beats a sequence-done clear but standby, halt and init clears beat a set
    always_comb begin
        go_next = go_reg;
        if (SEQ_DONE && (mode == hitc_pkg::MODE_INT
                || mode == hitc_pkg::MODE_EDGE)) begin
            go_next = 1'b0;
        end
        if (wr_fire) begin
            go_next = wd[hitc_pkg::FIRE_BIT];
        end
        if (mode == hitc_pkg::MODE_EDGE && fire_rise) begin
            go_next = ~go_reg;
        end
        if (mode == hitc_pkg::MODE_LEVEL) begin
            go_next = pin_fire;
        end
        if (standby || halt || init_req) begin
            go_next = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            go_reg <= 1'b0;
        end else if (CE) begin
            go_reg <= go_next;
        end
    end

    // continuous drive path
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            drv_en_reg <= 1'b0;
            drv_lvl_reg <= 8'h00;
            ffreq_reg <= 1'b0;
        end else if (CE) begin
            drv_en_reg <= is_cont(mode) && !standby && !halt
                && (st_reg == S_RUN);
            ffreq_reg <= is_cont(mode)
                && ctrl_reg[hitc_pkg::FIXED_FREQ_BIT]
                && cfg_reg.word[hitc_pkg::LRA_SEL_WORD][hitc_pkg::LRA_SEL_BIT];
            if (!is_cont(mode) || standby || halt || st_reg != S_RUN) begin
                drv_lvl_reg <= 8'h00;
            end else if (mode == hitc_pkg::MODE_DIRECT) begin
                drv_lvl_reg <= amp_reg;
            end else begin
                drv_lvl_reg <= ng_gate(INPUT_LEVEL, ctrl_reg[1:0]);
            end
        end
    end

    // supply reading while playing
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            supply_reg <= 8'h00;
        end else if (CE && (drv_en_reg || go_reg)) begin
            supply_reg <= SUPPLY_SAMPLE;
        end
    end

    // faults: flags sticky, set wins over clear
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ot_reg <= 1'b0;
            short_reg <= 1'b0;
            shut_reg <= 1'b0;
            rc_reg <= '0;
        end else if (CE) begin
            ot_reg <= pin_ot | (ot_reg & ~STATUS_CLEAR);
            short_reg <= pin_short | (short_reg & ~STATUS_CLEAR);
            if (pin_short && !shut_reg) begin
                shut_reg <= 1'b1;
                rc_reg <= '0;
            end else if (shut_reg) begin
                rc_reg <= (rc_reg == RC_LAST) ? '0
                    : RC_W'(rc_reg + 1'b1);
                if (recover) begin
                    shut_reg <= 1'b0;
                end
            end
        end
    end

    // protocol watchdog, idle in standby
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wd_reg <= '0;
            prst_reg <= 1'b0;
            pr_cnt_reg <= 3'd0;
        end else if (CE) begin
            if (standby || !busy || prst_reg) begin
                wd_reg <= '0;
            end else if (wd_reg == WD_LAST) begin
                wd_reg <= '0;
                prst_reg <= 1'b1;
                pr_cnt_reg <= 3'd0;
            end else begin
                wd_reg <= WD_W'(wd_reg + 1'b1);
            end
            if (prst_reg) begin
                pr_cnt_reg <= 3'(pr_cnt_reg + 3'd1);
                if (pr_cnt_reg == PR_LAST) begin
                    prst_reg <= 1'b0;
                end
            end
        end
    end

    assign DRIVE_EN = drv_en_reg;
    assign DRIVE_LEVEL = drv_lvl_reg;
    assign FIXED_FREQ = ffreq_reg;
    assign FIXED_PERIOD = period_reg;
    assign FIRE_BIT = go_reg;
    assign MODE = mode_reg[2:0];
    assign STANDBY = mode_reg[hitc_pkg::STANDBY_BIT];
    assign SHUTDOWN = shut_reg;
    assign STATUS = '{over_temp: ot_reg, short_fault: short_reg};
    assign SUPPLY_LEVEL = supply_reg;
    assign PROTO_RST = prst_reg;
    assign CONFIG = cfg_reg;
endmodule
`default_nettype wire

// file: hitc_pkg.sv
package hitc_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int WDOG_TIME_NS = 4330000;
    localparam int WDOG_CYCLES = WDOG_TIME_NS / CLK_PERIOD_NS;
    localparam int RECHECK_TIME_NS = 1000000;
    localparam int RECHECK_CYCLES = RECHECK_TIME_NS / CLK_PERIOD_NS;
    localparam int PRST_CYCLES = 4;

    // register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h01;
    localparam logic [7:0] ADDR_AMP = 8'h02;
    localparam logic [7:0] ADDR_FIRE = 8'h0c;
    localparam logic [7:0] ADDR_CFG_LO = 8'h16;
    localparam logic [7:0] ADDR_CFG_HI = 8'h1a;
    localparam logic [7:0] ADDR_CTRL = 8'h1d;
    localparam logic [7:0] ADDR_PERIOD = 8'h20;
    localparam logic [7:0] ADDR_SUPPLY = 8'h21;

    // field positions
    localparam int STANDBY_BIT = 6;
    localparam int DEV_RESET_BIT = 7;
    localparam int FIRE_BIT = 0;
    localparam int FIXED_FREQ_BIT = 5;
    localparam int LRA_SEL_BIT = 7;
    localparam int LRA_SEL_WORD = 4;

    // reset values
    localparam logic [7:0] MODE_RST = 8'h40;
    localparam logic [7:0] AMP_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [6:0] PERIOD_RST = 7'h33;
    localparam logic [7:0] CFG_RST = 8'h00;

    // noise gate thresholds, full scale 8'hff
    localparam logic [7:0] NG_LVL1 = 8'h0a;
    localparam logic [7:0] NG_LVL2 = 8'h14;
    localparam logic [7:0] NG_LVL3 = 8'h28;

    // retained storage layout
    localparam logic [2:0] OTP_MARK_ADDR = 3'h7;
    localparam logic [7:0] OTP_MARKER = 8'ha5;
    localparam logic [2:0] OTP_WORDS = 3'h5;

    typedef enum logic [2:0] {
        MODE_INT = 3'h0,
        MODE_EDGE = 3'h1,
        MODE_LEVEL = 3'h2,
        MODE_INPUT = 3'h3,
        MODE_AUDIO = 3'h4,
        MODE_DIRECT = 3'h5,
        MODE_DIAG = 3'h6,
        MODE_CAL = 3'h7
    } hitc_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } hitc_wr_t;

    typedef struct packed {
        logic [4:0][7:0] word;
    } hitc_cfg_t;

    typedef struct packed {
        logic over_temp;
        logic short_fault;
    } hitc_stat_t;

endpackage

// file: hitc_link_rx.sv
`timescale 1ns/1ps
`default_nettype none
// link-side capture of register writes; hands over by toggle
module hitc_link_rx (
    // link clock and reset
    input wire logic link_clk,
    input wire logic arst_n,
    // from the core domain
    input wire logic ce,
    input wire logic proto_rst,
    // write strobe and word, link clock
    input wire logic wr,
    input wire hitc_pkg::hitc_wr_t wr_in,
    // held word and its toggle
    output hitc_pkg::hitc_wr_t hold,
    output logic tgl
);
    logic ce_s1_reg, ce_s2_reg, pr_s1_reg, pr_s2_reg;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            ce_s1_reg <= 1'b0;
            ce_s2_reg <= 1'b0;
            pr_s1_reg <= 1'b0;
            pr_s2_reg <= 1'b0;
        end else begin
            ce_s1_reg <= ce;
            ce_s2_reg <= ce_s1_reg;
            pr_s1_reg <= proto_rst;
            pr_s2_reg <= pr_s1_reg;
        end
    end

    // writes during a protocol reset are dropped
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold <= '0;
            tgl <= 1'b0;
        end else if (ce_s2_reg && wr && !pr_s2_reg) begin
            hold <= wr_in;
            tgl <= ~tgl;
        end
    end
endmodule
`default_nettype wire

// file: hitc_otp_mem.sv
`timescale 1ns/1ps
`default_nettype none
// retained configuration store, registered read
module hitc_otp_mem (
    // clock
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // write port
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [7:0] wdata,
    // read port
    input wire logic [2:0] raddr,
    output logic [7:0] rdata
);
    // array has no reset so contents outlive a reset
    logic [7:0] mem [8];

    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// file: hitc_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hitc_core_chk #(
    parameter int WDOG_CYCLES = 50
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // inputs watched
    input wire logic LINK_BUSY,
    input wire logic EXT_FIRE_PIN,
    input wire logic OVER_TEMP_PIN,
    input wire logic SHORT_PIN,
    // outputs watched
    input wire logic DRIVE_EN,
    input wire logic [7:0] DRIVE_LEVEL,
    input wire logic FIRE_BIT,
    input wire logic [2:0] MODE,
    input wire logic STANDBY,
    input wire logic SHUTDOWN,
    input wire hitc_pkg::hitc_stat_t STATUS,
    input wire logic PROTO_RST
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // raw busy run length outside standby, sync lag allowed below
    int busy_cnt;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            busy_cnt <= 0;
        end else if (LINK_BUSY && !STANDBY) begin
            busy_cnt <= busy_cnt + 1;
        end else begin
            busy_cnt <= 0;
        end
    end
    property p_mode;
        DRIVE_EN |-> $past(MODE) == 3'h3 || $past(MODE) == 3'h5;
    endproperty
    a_mode: assert property (p_mode)
        else $error("drive outside continuous mode");
    property p_stby;
        STANDBY |=> !DRIVE_EN;
    endproperty
    a_stby: assert property (p_stby)
        else $error("drive in standby");
    property p_idle;
        !DRIVE_EN |-> DRIVE_LEVEL == 8'h00;
    endproperty
    a_idle: assert property (p_idle)
        else $error("level while idle");
    property p_shut;
        SHUTDOWN |=> !DRIVE_EN && !FIRE_BIT;
    endproperty
    a_shut: assert property (p_shut)
        else $error("activity in shutdown");
    property p_short;
        $rose(SHORT_PIN) |-> ##[1:4] STATUS.short_fault;
    endproperty
    a_short: assert property (p_short)
        else $error("short flag late");
    property p_ot;
        OVER_TEMP_PIN [*5] |-> STATUS.over_temp && !DRIVE_EN;
    endproperty
    a_ot: assert property (p_ot)
        else $error("no thermal halt");
    property p_lvl;
        (MODE == 3'h2 && !EXT_FIRE_PIN) [*4] |-> !FIRE_BIT;
    endproperty
    a_lvl: assert property (p_lvl)
        else $error("fire bit not following pin");
    property p_pw;
        $rose(PROTO_RST) |-> PROTO_RST [*4] ##1 !PROTO_RST;
    endproperty
    a_pw: assert property (p_pw)
        else $error("protocol reset width");
    property p_wd;
        $rose(PROTO_RST) |-> $past(busy_cnt, 4) >= WDOG_CYCLES - 8;
    endproperty
    a_wd: assert property (p_wd)
        else $error("protocol reset too early");
    property p_wsb;
        STANDBY [*3] |-> !$rose(PROTO_RST);
    endproperty
    a_wsb: assert property (p_wsb)
        else $error("watchdog acted in standby");
    c_drive: cover property (DRIVE_EN);
    c_fire: cover property ($rose(FIRE_BIT));
    c_prst: cover property ($rose(PROTO_RST));
endmodule
bind hitc_core hitc_core_chk #(.WDOG_CYCLES(WDOG_CYCLES)) i_hitc_core_chk (
    .CLK, .ARST_N, .LINK_BUSY, .EXT_FIRE_PIN, .OVER_TEMP_PIN, .SHORT_PIN,
    .DRIVE_EN, .DRIVE_LEVEL, .FIRE_BIT, .MODE, .STANDBY, .SHUTDOWN,
    .STATUS, .PROTO_RST
);
`default_nettype wire

// file: hitc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hitc_host_model (
    // link side
    output logic LINK_CLK,
    output logic LINK_WR,
    output hitc_pkg::hitc_wr_t LINK_WORD,
    output logic LINK_BUSY,
    // trigger pin
    output logic EXT_FIRE_PIN
);
    initial begin
        LINK_CLK = 1'b0;
        LINK_WR = 1'b0;
        LINK_WORD = 16'h0000;
        LINK_BUSY = 1'b0;
        EXT_FIRE_PIN = 1'b0;
    end
    // link clock runs only inside frames and during and just after reset
    task automatic tick(input int n);
        repeat (n) begin
            #7.5 LINK_CLK = 1'b1;
            #7.5 LINK_CLK = 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        LINK_BUSY = 1'b1;
        LINK_WORD = {a, d};
        LINK_WR = 1'b1;
        #7.5 LINK_CLK = 1'b1;
        #1 LINK_WR = 1'b0;
        // released word shows the inverse, not the last value
        LINK_WORD = ~{a, d};
        #6.5 LINK_CLK = 1'b0;
        tick(6);
        LINK_BUSY = 1'b0;
    endtask
    task automatic hang(input int t);
        LINK_BUSY = 1'b1;
        #t LINK_BUSY = 1'b0;
    endtask
    task automatic pulse;
        EXT_FIRE_PIN = 1'b1;
        #1200 EXT_FIRE_PIN = 1'b0;
    endtask
    task automatic set_pin(input logic v);
        EXT_FIRE_PIN = v;
    endtask
endmodule
`default_nettype wire

// file: hitc_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hitc_core_bench;
    localparam int WD = 50;
    localparam int RC = 20;
    typedef struct packed {
        logic [7:0] mode, ctrl, amp, inl;
        logic en, ff;
        logic [7:0] lvl;
    } hitc_row_t;
    hitc_row_t rows [9] = '{
        '{8'h05, 8'h00, 8'h5a, 8'h00, 1'b1, 1'b0, 8'h5a},
        '{8'h05, 8'h20, 8'hff, 8'h00, 1'b1, 1'b1, 8'hff},
        '{8'h03, 8'h00, 8'h00, 8'h80, 1'b1, 1'b0, 8'h80},
        '{8'h03, 8'h01, 8'h00, 8'h09, 1'b1, 1'b0, 8'h00},
        '{8'h03, 8'h01, 8'h00, 8'h0a, 1'b1, 1'b0, 8'h0a},
        '{8'h03, 8'h03, 8'h00, 8'h27, 1'b1, 1'b0, 8'h00},
        '{8'h03, 8'h23, 8'h00, 8'hff, 1'b1, 1'b1, 8'hff},
        '{8'h00, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0, 8'h00},
        '{8'h45, 8'h00, 8'h33, 8'h00, 1'b0, 1'b0, 8'h00}
    };
    logic CLK = 1'b0, ARST_N = 1'b0, CE = 1'b1;
    logic OVER_TEMP_PIN = 1'b0, SHORT_PIN = 1'b0, SEQ_DONE = 1'b0;
    logic OTP_PROGRAM = 1'b0, STATUS_CLEAR = 1'b0;
    logic [7:0] INPUT_LEVEL = 8'h00, SUPPLY_SAMPLE = 8'h00;
    logic LINK_CLK, LINK_WR, LINK_BUSY, EXT_FIRE_PIN;
    hitc_pkg::hitc_wr_t LINK_WORD;
    logic DRIVE_EN, FIXED_FREQ, FIRE_BIT, STANDBY, SHUTDOWN, PROTO_RST;
    logic [7:0] DRIVE_LEVEL, SUPPLY_LEVEL;
    logic [6:0] FIXED_PERIOD;
    logic [2:0] MODE;
    hitc_pkg::hitc_stat_t STATUS;
    hitc_pkg::hitc_cfg_t CONFIG;
    int err_count = 0, comparisons = 0, n_prst = 0;
    logic prst_q = 1'b0;
    always #10 CLK = ~CLK;
    hitc_core #(.WDOG_CYCLES(WD), .RECHECK_CYCLES(RC)) i_hitc_core (
        .CLK, .ARST_N, .CE, .LINK_CLK, .LINK_WR, .LINK_WORD, .LINK_BUSY,
        .EXT_FIRE_PIN, .OVER_TEMP_PIN, .SHORT_PIN, .INPUT_LEVEL,
        .SUPPLY_SAMPLE, .SEQ_DONE, .OTP_PROGRAM, .STATUS_CLEAR,
        .DRIVE_EN, .DRIVE_LEVEL, .FIXED_FREQ, .FIXED_PERIOD, .FIRE_BIT,
        .MODE, .STANDBY, .SHUTDOWN, .STATUS, .SUPPLY_LEVEL, .PROTO_RST,
        .CONFIG
    );
    hitc_host_model i_hitc_host_model (
        .LINK_CLK, .LINK_WR, .LINK_WORD, .LINK_BUSY, .EXT_FIRE_PIN
    );
    // counts protocol reset pulses
    always @(posedge CLK) begin
        prst_q <= PROTO_RST;
        if (PROTO_RST && !prst_q) begin
            n_prst <= n_prst + 1;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task automatic chk_val(input logic [39:0] g, input logic [39:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_val({39'h0, g}, {39'h0, e});
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        i_hitc_host_model.wr(a, d);
        cyc(12);
    endtask
    // one-cycle pulse: 0 status clear, 1 sequence done, 2 program store
    task automatic strobe(input int k);
        {OTP_PROGRAM, SEQ_DONE, STATUS_CLEAR} <= 3'(1 << k);
        cyc(1);
        {OTP_PROGRAM, SEQ_DONE, STATUS_CLEAR} <= 3'h0;
        cyc(3);
    endtask
    task automatic reset_dut;
        ARST_N <= 1'b0;
        i_hitc_host_model.tick(3);
        cyc(16);
        ARST_N <= 1'b1;
        // link side needs two link edges to see the enable again
        i_hitc_host_model.tick(3);
        cyc(12);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        close_out();
    end
    initial begin
        reset_dut();
        chk_bit(STANDBY, 1'b1);
        chk_val(MODE, 3'h0);
        chk_val(FIXED_PERIOD, 7'h33);
        w(hitc_pkg::ADDR_CFG_HI, 8'h80);
        foreach (rows[i]) begin
            w(hitc_pkg::ADDR_CTRL, rows[i].ctrl);
            w(hitc_pkg::ADDR_AMP, rows[i].amp);
            INPUT_LEVEL <= rows[i].inl;
            w(hitc_pkg::ADDR_MODE, rows[i].mode);
            chk_bit(DRIVE_EN, rows[i].en);
            chk_val(DRIVE_LEVEL, rows[i].lvl);
            chk_bit(FIXED_FREQ, rows[i].ff);
        end
        $display("test table done");
        w(hitc_pkg::ADDR_PERIOD, 8'h15);
        chk_val(FIXED_PERIOD, 7'h15);
        w(hitc_pkg::ADDR_MODE, 8'h05);
        SUPPLY_SAMPLE <= 8'h9c;
        cyc(4);
        chk_val(SUPPLY_LEVEL, 8'h9c);
        OVER_TEMP_PIN <= 1'b1;
        cyc(8);
        chk_bit(DRIVE_EN, 1'b0);
        chk_bit(STATUS.over_temp, 1'b1);
        OVER_TEMP_PIN <= 1'b0;
        // let the pin clear through its synchroniser, set beats clear
        cyc(3);
        strobe(0);
        chk_bit(STATUS.over_temp, 1'b0);
        $display("test drive done");
        w(hitc_pkg::ADDR_MODE, 8'h00);
        w(hitc_pkg::ADDR_FIRE, 8'h01);
        chk_bit(FIRE_BIT, 1'b1);
        w(hitc_pkg::ADDR_FIRE, 8'h00);
        chk_bit(FIRE_BIT, 1'b0);
        w(hitc_pkg::ADDR_FIRE, 8'h01);
        strobe(1);
        chk_bit(FIRE_BIT, 1'b0);
        w(hitc_pkg::ADDR_MODE, 8'h01);
        i_hitc_host_model.pulse();
        cyc(5);
        chk_bit(FIRE_BIT, 1'b1);
        i_hitc_host_model.pulse();
        cyc(5);
        chk_bit(FIRE_BIT, 1'b0);
        i_hitc_host_model.pulse();
        w(hitc_pkg::ADDR_FIRE, 8'h00);
        chk_bit(FIRE_BIT, 1'b0);
        w(hitc_pkg::ADDR_MODE, 8'h02);
        i_hitc_host_model.set_pin(1'b1);
        cyc(60);
        chk_bit(FIRE_BIT, 1'b1);
        i_hitc_host_model.set_pin(1'b0);
        cyc(6);
        chk_bit(FIRE_BIT, 1'b0);
        $display("test trigger done");
        i_hitc_host_model.hang(1400);
        cyc(10);
        chk_val(n_prst, 1);
        w(hitc_pkg::ADDR_MODE, 8'h42);
        i_hitc_host_model.hang(2000);
        cyc(10);
        chk_val(n_prst, 1);
        $display("test watchdog done");
        for (int k = 0; k < 5; k++) begin
            w(8'(hitc_pkg::ADDR_CFG_LO + k), 8'(8'h10 + k));
        end
        strobe(2);
        cyc(10);
        reset_dut();
        chk_val(CONFIG, 40'h1413121110);
        $display("test storage done");
        w(hitc_pkg::ADDR_MODE, 8'h05);
        SHORT_PIN <= 1'b1;
        cyc(6);
        chk_bit(SHUTDOWN, 1'b1);
        chk_bit(STATUS.short_fault, 1'b1);
        SHORT_PIN <= 1'b0;
        cyc(3 * RC + 20);
        chk_bit(SHUTDOWN, 1'b0);
        chk_bit(STANDBY, 1'b1);
        chk_bit(STATUS.short_fault, 1'b1);
        w(hitc_pkg::ADDR_MODE, 8'h05);
        w(hitc_pkg::ADDR_MODE, 8'h85);
        chk_val(MODE, 3'h0);
        chk_bit(STANDBY, 1'b1);
        $display("test short done");
        close_out();
    end
endmodule
`default_nettype wire
